// ==== rtl/cvp_pkg.sv ====
// constants of the cell voltage protection block
package cvp_pkg;

  // ==========================================================================
  // code format and register map
  localparam int                 CODE_W      = 12;
  localparam int                 NUM_CFG     = 11;
  localparam int                 IDX_OV_LOCK = 0;
  localparam int                 IDX_UV_LOCK = 1;
  localparam int                 IDX_OV_LVL  = 2;
  localparam int                 IDX_OV_REC  = 3;
  localparam int                 IDX_OV_DLY  = 4;
  localparam int                 IDX_UV_LVL  = 5;
  localparam int                 IDX_UV_REC  = 6;
  localparam int                 IDX_UV_DLY  = 7;
  localparam int                 IDX_SLP_LVL = 8;
  localparam int                 IDX_SLP_DLY = 9;
  localparam int                 IDX_PC_LVL  = 10;
  localparam int                 IDX_STATUS  = 11;

  // ==========================================================================
  // values after reset, indexed as above
  localparam logic [11:0] CFG_RST [NUM_CFG] = '{
    12'he80, 12'h600, 12'he2a, 12'hdd5, 12'h201, 12'h900,
    12'ha00, 12'h201, 12'h6aa, 12'h201, 12'h7aa
  };

  // ==========================================================================
  // status bit positions
  localparam int                 ST_OV       = 0;
  localparam int                 ST_UV       = 1;
  localparam int                 ST_OV_LOCK  = 2;
  localparam int                 ST_UV_LOCK  = 3;
  localparam int                 ST_SLEEP    = 4;
  localparam int                 ST_PRECHG   = 5;

  // ==========================================================================
  // delay code fields: value in [8:0], unit in [10:9] (00 ms, else s)
  localparam int                 DLY_VAL_MSB = 8;
  localparam int                 DLY_UNIT_LSB = 9;
  localparam int                 DLY_UNIT_MSB = 10;

  // ==========================================================================
  // timing
  localparam int                 CLK_PERIOD_NS  = 50;
  localparam int                 MS_TIME_NS     = 1000000;
  localparam int                 MS_CYCLES      = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int                 MS_PER_S       = 1000;
  localparam int                 UV_EXTRA_S     = 2;
  localparam int                 UV_EXTRA_MS    = UV_EXTRA_S * MS_PER_S;
  localparam int                 LOCK_SAMPLES   = 5;
  // 117 mV at 4.8 V / 4096 per code
  localparam logic [12:0]        PC_HYST_CODES  = 13'h0064;
  localparam int                 TMR_W          = 21;

endpackage

// ==== rtl/cvp_top.sv ====
// cell voltage protection: thresholds, lockouts, timers and wishbone registers
`timescale 1ns/1ps
module cvp_top #(
  parameter int P_MS_CYCLES = cvp_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // cell samples from the measurement front end
  input  wire logic        i_smp_valid,
  input  wire logic [11:0] i_smp_code,
  input  wire logic        i_smp_last,
  // protection flags
  output logic             o_overvoltage,
  output logic             o_undervoltage,
  output logic             o_ov_lockout,
  output logic             o_uv_lockout,
  output logic             o_sleep,
  output logic             o_precharge
);

  // ==========================================================================
  // configuration registers
  logic [11:0] cfg_q [cvp_pkg::NUM_CFG];
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [3:0]  idx;
  logic        acc_en;
  logic [5:0]  status;
  logic [31:0] rd_word;

  assign idx    = i_wb_adr[5:2];
  assign acc_en = i_wb_cyc && i_wb_stb && !ack_q;

  // one writer per entry: a write to the status word or an unmapped word touches nothing
  for (genvar e = 0; e < cvp_pkg::NUM_CFG; e++) begin : g_cfg
    logic wr_hit;
    assign wr_hit = acc_en && i_wb_we && (int'(idx) == e);
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cfg_q[e] <= cvp_pkg::CFG_RST[e];
      end else if (wr_hit) begin
        if (i_wb_sel[0]) begin
          cfg_q[e][7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          cfg_q[e][11:8] <= i_wb_dat[11:8];
        end
      end
    end
  end

  // read word picked without ever indexing past the table
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int k = 0; k < cvp_pkg::NUM_CFG; k++) begin
      if (int'(idx) == k) begin
        rd_word = {20'h00000, cfg_q[k]};
      end
    end
    if (int'(idx) == cvp_pkg::IDX_STATUS) begin
      rd_word = {26'h0000000, status};
    end
  end

  // answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc_en;
      if (acc_en && !i_wb_we) begin
        rdat_q <= rd_word;
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ==========================================================================
  // per-sample comparisons, gathered over one scan of all cells
  localparam int NHIT = 9;
  // positions in the hit vector
  localparam int H_OV_LOCK = 0;
  localparam int H_UV_LOCK = 1;
  localparam int H_OV      = 2;
  localparam int H_OV_REC  = 3;
  localparam int H_UV      = 4;
  localparam int H_UV_REC  = 5;
  localparam int H_SLEEP   = 6;
  localparam int H_PC      = 7;
  localparam int H_PC_REL  = 8;

  logic [NHIT-1:0] hit;
  logic [NHIT-1:0] acc_q;
  logic [NHIT-1:0] scan_q;
  logic [NHIT-1:0] merged;
  logic            scan_done_q;
  logic [12:0]     pc_rel;

  assign pc_rel = {1'b0, cfg_q[cvp_pkg::IDX_PC_LVL]} + cvp_pkg::PC_HYST_CODES;

  // recovery and hysteresis bits mark a cell not yet past the level: a clear needs none
  always_comb begin
    hit[H_OV_LOCK] = i_smp_code > cfg_q[cvp_pkg::IDX_OV_LOCK];
    hit[H_UV_LOCK] = i_smp_code < cfg_q[cvp_pkg::IDX_UV_LOCK];
    hit[H_OV]      = i_smp_code > cfg_q[cvp_pkg::IDX_OV_LVL];
    hit[H_OV_REC]  = i_smp_code >= cfg_q[cvp_pkg::IDX_OV_REC];
    hit[H_UV]      = i_smp_code < cfg_q[cvp_pkg::IDX_UV_LVL];
    hit[H_UV_REC]  = i_smp_code <= cfg_q[cvp_pkg::IDX_UV_REC];
    hit[H_SLEEP]   = i_smp_code < cfg_q[cvp_pkg::IDX_SLP_LVL];
    hit[H_PC]      = i_smp_code < cfg_q[cvp_pkg::IDX_PC_LVL];
    hit[H_PC_REL]  = {1'b0, i_smp_code} <= pc_rel;
  end

  // hits gather over a scan and are judged once its last cell is in
  assign merged = acc_q | hit;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q       <= '0;
      scan_q      <= '0;
      scan_done_q <= 1'b0;
    end else begin
      scan_done_q <= i_smp_valid && i_smp_last;
      if (i_smp_valid) begin
        acc_q <= i_smp_last ? '0 : merged;
        if (i_smp_last) begin
          scan_q <= merged;
        end
      end
    end
  end

  // ==========================================================================
  // lockouts: 0 overvoltage, 1 undervoltage
  logic [1:0] lk_set;
  logic [1:0] lk_clr;
  logic [1:0] lk_q;

  assign lk_set = {scan_q[H_UV_LOCK], scan_q[H_OV_LOCK]};
  assign lk_clr = {~scan_q[H_UV_REC], ~scan_q[H_OV_REC]};

  // a scan that neither sets nor clears keeps the lock and restarts the count
  for (genvar g = 0; g < 2; g++) begin : g_lock
    // the count stops at five, so a long run over the limit cannot wrap
    logic [2:0] cnt_q;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cnt_q   <= 3'h0;
        lk_q[g] <= 1'b0;
      end else if (scan_done_q) begin
        if (lk_set[g]) begin
          if (int'(cnt_q) < cvp_pkg::LOCK_SAMPLES) begin
            cnt_q <= cnt_q + 3'h1;
          end
          if (int'(cnt_q) >= cvp_pkg::LOCK_SAMPLES - 1) begin
            lk_q[g] <= 1'b1;
          end
        end else begin
          cnt_q <= 3'h0;
          if (lk_clr[g]) begin
            lk_q[g] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // millisecond tick
  // free running: the first step of a delay may be up to one tick short
  logic [$clog2(P_MS_CYCLES)-1:0] div_q;
  logic                           ms_tick_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q     <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= int'(div_q) == P_MS_CYCLES - 1;
      if (int'(div_q) == P_MS_CYCLES - 1) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // delay code to milliseconds
  // bit 11 of a delay code is kept but has no effect
  function automatic logic [cvp_pkg::TMR_W-1:0] dly_ms(input logic [11:0] code);
    logic [cvp_pkg::TMR_W-1:0] v;
    v = cvp_pkg::TMR_W'(code[cvp_pkg::DLY_VAL_MSB:0]);
    if (code[cvp_pkg::DLY_UNIT_MSB:cvp_pkg::DLY_UNIT_LSB] == 2'b00) begin
      dly_ms = v;
    end else begin
      dly_ms = cvp_pkg::TMR_W'(v * cvp_pkg::TMR_W'(cvp_pkg::MS_PER_S));
    end
  endfunction

  // ==========================================================================
  // qualified conditions: 0 overvoltage, 1 undervoltage, 2 sleep
  logic [2:0]                tm_set;
  logic [2:0]                tm_clr;
  logic [2:0]                tm_q;
  logic [cvp_pkg::TMR_W-1:0] tgt_set [3];
  logic [cvp_pkg::TMR_W-1:0] tgt_clr [3];

  assign tm_set = {scan_q[H_SLEEP], scan_q[H_UV], scan_q[H_OV]};
  assign tm_clr = {~scan_q[H_SLEEP], ~scan_q[H_UV_REC], ~scan_q[H_OV_REC]};

  // undervoltage release runs two seconds longer than its detection
  always_comb begin
    tgt_set[0] = dly_ms(cfg_q[cvp_pkg::IDX_OV_DLY]);
    tgt_clr[0] = tgt_set[0];
    tgt_set[1] = dly_ms(cfg_q[cvp_pkg::IDX_UV_DLY]);
    tgt_clr[1] = tgt_set[1] + cvp_pkg::TMR_W'(cvp_pkg::UV_EXTRA_MS);
    tgt_set[2] = dly_ms(cfg_q[cvp_pkg::IDX_SLP_DLY]);
    tgt_clr[2] = tgt_set[2];
  end

  // the count restarts whenever the condition drops, so a delay is one unbroken span
  // a zero delay still takes one clock to act
  for (genvar g = 0; g < 3; g++) begin : g_tmr
    logic [cvp_pkg::TMR_W-1:0] cnt_q;
    logic                      run;
    logic [cvp_pkg::TMR_W-1:0] tgt;
    assign run = tm_q[g] ? tm_clr[g] : tm_set[g];
    assign tgt = tm_q[g] ? tgt_clr[g] : tgt_set[g];
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cnt_q   <= '0;
        tm_q[g] <= 1'b0;
      end else if (!run) begin
        cnt_q <= '0;
      end else if (cnt_q >= tgt) begin
        tm_q[g] <= ~tm_q[g];
        cnt_q   <= '0;
      end else if (ms_tick_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // precharge with hysteresis
  // between the level and the level plus hysteresis the flag holds its state
  logic pc_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_q <= 1'b0;
    end else if (scan_done_q) begin
      if (scan_q[H_PC]) begin
        pc_q <= 1'b1;
      end else if (!scan_q[H_PC_REL]) begin
        pc_q <= 1'b0;
      end
    end
  end

  // status bits, low to high: ov, uv, ov lockout, uv lockout, sleep, precharge
  assign status = {pc_q, tm_q[2], lk_q[1], lk_q[0], tm_q[1], tm_q[0]};

  // flags leave straight from their registers
  assign o_overvoltage  = tm_q[0];
  assign o_undervoltage = tm_q[1];
  assign o_ov_lockout   = lk_q[0];
  assign o_uv_lockout   = lk_q[1];
  assign o_sleep        = tm_q[2];
  assign o_precharge    = pc_q;

endmodule

// ==== test/cvp_cell_source.sv ====
// cell sample source model: four cells per scan, one sample a cycle
`timescale 1ns/1ps
module cvp_cell_source (
  // control
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [47:0] i_cells,
  // samples
  output logic             o_valid,
  output logic [11:0]      o_code,
  output logic             o_last
);
  logic [2:0] left_q = 3'h0;
  always_ff @(posedge i_clk) begin
    if (i_go) left_q <= 3'h4;
    else if (left_q != 3'h0) left_q <= left_q - 3'h1;
  end
  assign o_valid = left_q != 3'h0;
  assign o_last  = left_q == 3'h1;
  // between scans the code line shows the inverted last sample
  assign o_code  = o_valid ? i_cells[12*left_q-1 -: 12] : ~i_cells[11:0];
endmodule

// ==== test/cvp_top_properties.sv ====
// assertions on the ports of the protection block
`timescale 1ns/1ps
module cvp_top_properties (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_smp_valid,
  input wire logic        i_smp_last,
  input wire logic        o_ov_lockout,
  input wire logic        o_uv_lockout,
  input wire logic        o_precharge
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================================
  // scans seen since reset, saturating
  logic [2:0] scans_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) scans_q <= 3'h0;
    else if (i_smp_valid && i_smp_last && scans_q != 3'h7) scans_q <= scans_q + 3'h1;
  end
  // ==========================================================================
  AST_ACK_TAKE: assert property (o_wb_ack == $past(i_wb_cyc && i_wb_stb && !o_wb_ack))
    else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  AST_DAT_HI: assert property (o_wb_ack |-> o_wb_dat[31:12] == 20'h0)
    else $error("read data above code width");
  AST_OVLK_SCAN: assert property ($changed(o_ov_lockout) |-> $past(i_smp_last && i_smp_valid, 2))
    else $error("ov lockout moved outside scan");
  AST_UVLK_SCAN: assert property (!$past(i_smp_valid && i_smp_last, 2) |-> $stable(o_uv_lockout))
    else $error("uv lockout moved outside scan");
  AST_PC_SCAN: assert property (!$past(i_smp_valid && i_smp_last, 2) |-> $stable(o_precharge))
    else $error("precharge moved outside scan");
  AST_OVLK_FIVE: assert property ($rose(o_ov_lockout) |-> scans_q >= 3'h5)
    else $error("ov lockout before five scans");
  AST_UVLK_FIVE: assert property ($rose(o_uv_lockout) |-> scans_q >= 3'h5)
    else $error("uv lockout before five scans");
  COV_OVLK: cover property ($rose(o_ov_lockout));
  COV_UVLK: cover property ($fell(o_uv_lockout));
  COV_PC: cover property ($fell(o_precharge));
endmodule
bind cvp_top cvp_top_properties u_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_smp_valid(i_smp_valid), .i_smp_last(i_smp_last), .o_ov_lockout(o_ov_lockout),
  .o_uv_lockout(o_uv_lockout), .o_precharge(o_precharge));

// ==== test/tb_cvp_top.sv ====
// self-checking bench for the cell voltage protection block
`timescale 1ns/1ps
module tb_cvp_top;
  logic        clk, rst_b, cyc, stb, we, go, ack, sv, sl;
  logic        ov, uv, overvoltage_level, undervoltage_level, slp, pc;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [11:0] sc;
  logic [31:0] wd, dat_o, rd;
  logic [47:0] cells;
  int          n_fail, check_count;

  cvp_top #(.P_MS_CYCLES(4)) DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd),
    .o_wb_dat(dat_o), .o_wb_ack(ack), .i_smp_valid(sv), .i_smp_code(sc), .i_smp_last(sl),
    .o_overvoltage(ov), .o_undervoltage(uv), .o_ov_lockout(overvoltage_level), .o_uv_lockout(undervoltage_level),
    .o_sleep(slp), .o_precharge(pc));
  cvp_cell_source u_src (.i_clk(clk), .i_go(go), .i_cells(cells), .o_valid(sv),
    .o_code(sc), .o_last(sl));

  task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic chkf(input string nm, input logic e, input logic g);
    chkw(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // one scan, odd cell in second place, others mid-range
  task automatic scan(input logic [11:0] c);
    cells <= {12'hc00, c, 24'hc00c00};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < cvp_pkg::NUM_CFG; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chkw("reset value", {20'h0, cvp_pkg::CFG_RST[i]}, rd);
    end
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h08, 32'h0);
    chkw("ov level width", 32'hfff, rd);
    sel <= 4'h1;
    wb(1'b1, 8'h08, 32'h0);
    sel <= 4'hf;
    wb(1'b0, 8'h08, 32'h0);
    chkw("ov level low byte", 32'hf00, rd);
    wb(1'b1, 8'h08, 32'he2a);
    wb(1'b1, 8'h2c, 32'h3f);
    wb(1'b0, 8'h2c, 32'h0);
    chkw("status", 32'h0, rd);
    wb(1'b0, 8'h30, 32'h0);
    chkw("unmapped", 32'h0, rd);
  endtask
  task automatic t_ov;
    wb(1'b1, 8'h10, 32'h005);
    scan(12'he2b);
    repeat (12) @(posedge clk);
    chkf("ov early", 1'b0, ov);
    repeat (18) @(posedge clk);
    chkf("ov", 1'b1, ov);
    repeat (4) scan(12'he81);
    chkf("ov lockout early", 1'b0, overvoltage_level);
    scan(12'he81);
    chkf("ov lockout", 1'b1, overvoltage_level);
    scan(12'hdd5);
    repeat (30) @(posedge clk);
    chkf("ov held", 1'b1, ov);
    chkf("ov lockout held", 1'b1, overvoltage_level);
    scan(12'hdd4);
    chkf("ov lockout clear", 1'b0, overvoltage_level);
    repeat (30) @(posedge clk);
    chkf("ov clear", 1'b0, ov);
  endtask
  task automatic t_uv;
    wb(1'b1, 8'h1c, 32'h000);
    scan(12'h5ff);
    chkf("uv", 1'b1, uv);
    chkf("precharge", 1'b1, pc);
    repeat (4) scan(12'h5ff);
    chkf("uv lockout", 1'b1, undervoltage_level);
    chkf("sleep early", 1'b0, slp);
    repeat (4000) @(posedge clk);
    chkf("sleep", 1'b1, slp);
    wb(1'b0, 8'h2c, 32'h0);
    chkw("status", 32'h3a, rd);
    scan(12'h7a9);
    scan(12'h80e);
    chkf("precharge hysteresis", 1'b1, pc);
    scan(12'ha01);
    chkf("uv lockout clear", 1'b0, undervoltage_level);
    chkf("precharge clear", 1'b0, pc);
    repeat (7900) @(posedge clk);
    chkf("uv release early", 1'b1, uv);
    repeat (200) @(posedge clk);
    chkf("uv release", 1'b0, uv);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    results;
  end
  initial begin
    {rst_b, cyc, stb, we, go, adr, wd, cells} = '0;
    sel = 4'hf;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_ov;
    t_uv;
    results;
  end
endmodule
